// >>> mmdec_consts.vh
`ifndef MMDEC_CONSTS_VH
`define MMDEC_CONSTS_VH
// Bank index field: top four address bits
`define MMDEC_BANK_MSB 31
`define MMDEC_BANK_LSB 28
// Bank numbers
`define MMDEC_BANK_INT 4'h0
`define MMDEC_BANK_EXT_LO 4'h1
`define MMDEC_BANK_EXT_HI 4'h8
`define MMDEC_BANK_PERIPH 4'hF
// Boot window: 0x0000_0000 .. 0x000F_FFFF, bits 27:20 zero
`define MMDEC_BOOT_MSB 27
`define MMDEC_BOOT_LSB 20
// Internal region second level: 1 Mbyte slots, bits 23:20
`define MMDEC_ISLOT_MSB 23
`define MMDEC_ISLOT_LSB 20
`define MMDEC_ISLOT_ROM 4'h1
`define MMDEC_ISLOT_SRAM0 4'h2
`define MMDEC_ISLOT_SRAM1 4'h3
// SRAM sizes in bytes: 96K and 64K
`define MMDEC_SRAM0_BYTES 32'h0001_8000
`define MMDEC_SRAM1_BYTES 32'h0001_0000
// System controller window: 0xFFFF_C000 .. 0xFFFF_FFFF
`define MMDEC_SYSC_BASE 32'hFFFF_C000
// External address width: 26 bits
`define MMDEC_EXT_AW 26
// Static controller reset defaults: byte select, 16-bit, cs strobing
`define MMDEC_SMC_BYTE_SEL 1'b1
`define MMDEC_SMC_DBW16 2'h1
`define MMDEC_SMC_CS_STROBE 1'b1
// Target codes
`define MMDEC_TGT_NONE 3'h0
`define MMDEC_TGT_ROM 3'h1
`define MMDEC_TGT_SRAM0 3'h2
`define MMDEC_TGT_SRAM1 3'h3
`define MMDEC_TGT_EXT 3'h4
`define MMDEC_TGT_PERIPH 3'h5
`endif

// >>> mmdec_lane.v
`include "mmdec_consts.vh"
`default_nettype none
// One per-master decoder: registers a target choice per request
module mmdec_lane (
  input wire ref_clk_i, // Master clock
  input wire nrst_i, // Async reset, active low
  input wire boot_rom_i, // Boot window targets ROM when high
  input wire boot_en_i, // This master sees the boot window
  input wire sdram_on_cs1_i, // Bank two served by SDRAM controller
  input wire req_i, // Access request
  input wire [31:0] addr_i, // Access address
  output reg sel_valid_o, // Decoded result valid
  output reg [2:0] tgt_o, // Selected target
  output reg [2:0] cs_o, // External chip select index
  output reg sdram_o, // External access uses SDRAM controller
  output reg [25:0] ext_addr_o, // External address bits
  output reg [19:0] int_addr_o, // Internal memory offset
  output reg sysc_o, // Peripheral access hits system controller
  output reg error_o // Abort answer pulse
);
  reg [2:0] tgt_d; // Combinational target
  reg [3:0] bank; // Top address nibble
  reg [3:0] islot; // Internal second-level slot
  reg boot_hit; // Address inside boot window

  // Decode address into a target
  always @* begin
    bank = addr_i[`MMDEC_BANK_MSB:`MMDEC_BANK_LSB]; // [R01]
    islot = addr_i[`MMDEC_ISLOT_MSB:`MMDEC_ISLOT_LSB];
    boot_hit = (addr_i[`MMDEC_BOOT_MSB:`MMDEC_BOOT_LSB] == 8'h00);
    tgt_d = `MMDEC_TGT_NONE;
    if (bank == `MMDEC_BANK_INT) begin // [R03]
      if (boot_hit && boot_en_i) begin // [R07] [R08]
        tgt_d = boot_rom_i ? `MMDEC_TGT_ROM : `MMDEC_TGT_EXT; // [R09] [R10]
      end else if (boot_hit) begin
        tgt_d = `MMDEC_TGT_ROM; // Other masters: fixed ROM view
      end else if (islot == `MMDEC_ISLOT_ROM) begin
        tgt_d = `MMDEC_TGT_ROM;
      end else if (islot == `MMDEC_ISLOT_SRAM0 &&
                   {12'h000, addr_i[19:0]} < `MMDEC_SRAM0_BYTES) begin
        tgt_d = `MMDEC_TGT_SRAM0; // [R18]
      end else if (islot == `MMDEC_ISLOT_SRAM1 &&
                   {12'h000, addr_i[19:0]} < `MMDEC_SRAM1_BYTES) begin
        tgt_d = `MMDEC_TGT_SRAM1; // [R18]
      end
    end else if (bank >= `MMDEC_BANK_EXT_LO &&
                 bank <= `MMDEC_BANK_EXT_HI) begin
      tgt_d = `MMDEC_TGT_EXT; // [R02] [R12]
    end else if (bank == `MMDEC_BANK_PERIPH) begin
      tgt_d = `MMDEC_TGT_PERIPH; // [R04]
    end
  end

  // Register one answer per request
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_valid_o <= 1'b0;
      tgt_o <= `MMDEC_TGT_NONE;
      cs_o <= 3'h0;
      sdram_o <= 1'b0;
      ext_addr_o <= 26'h0000000;
      int_addr_o <= 20'h00000;
      sysc_o <= 1'b0;
      error_o <= 1'b0;
    end else begin
      sel_valid_o <= req_i && (tgt_d != `MMDEC_TGT_NONE);
      tgt_o <= req_i ? tgt_d : `MMDEC_TGT_NONE; // [R21] nothing selected
      error_o <= req_i && (tgt_d == `MMDEC_TGT_NONE); // [R05] [R21]
      int_addr_o <= addr_i[19:0];
      ext_addr_o <= addr_i[`MMDEC_EXT_AW-1:0]; // [R16]
      sysc_o <= req_i && (addr_i >= `MMDEC_SYSC_BASE); // [R17]
      if (bank == `MMDEC_BANK_INT) begin
        cs_o <= 3'h0; // [R09] boot on select zero
      end else begin
        cs_o <= bank[2:0] - 3'h1; // [R02] bank 1..8 to select 0..7
      end
      sdram_o <= (bank == 4'h2) && sdram_on_cs1_i; // [R13]
    end
  end
endmodule // mmdec_lane
`default_nettype wire

// >>> mmdec_top.v
`include "mmdec_consts.vh"
`default_nettype none
// Function
// R01 - Sixteen 256 Mbyte banks from top nibble
// R02 - Banks one to eight reach external selects
// R03 - Bank zero reaches internal memories, second level
// R04 - Bank fifteen reaches peripheral bridge
// R05 - Unused banks abort to requester
// R06 - Each master has its own decoder
// R07 - Processor address zero has two candidates
// R08 - Low 1 Mbyte is boot window
// R09 - Boot select low maps select zero
// R10 - Boot select high maps embedded ROM
// R11 - Static controller resets byte-select, 16-bit
// R12 - Each select owns 256 Mbyte region
// R13 - Region 0x2000_0000 SDRAM or select one
// R14 - Select three static with NAND option
// R15 - Selects four, five static with card slot
// R16 - External address up to 26 bits
// R17 - System controller in top 16 Kbytes
// R18 - Two SRAM slaves, single cycle each
// R19 - Configuration picks select assignment
// R20 - Boot select sampled at reset
// R21 - Undecoded access gives ERROR, no select
module mmdec_top (
  input wire ref_clk_i, // Master clock, 20 MHz
  input wire nrst_i, // Async reset, active low
  input wire boot_source_select_pin_i, // Boot source pin
  input wire cfg_sdram_on_cs1_i, // Config: SDRAM on select one
  input wire cfg_nand_on_cs3_i, // Config: NAND logic on select three
  input wire cfg_card_on_cs45_i, // Config: card slot logic on four, five
  input wire m0_req_i, // Processor request
  input wire [31:0] m0_addr_i, // Processor address
  input wire m1_req_i, // DMA request
  input wire [31:0] m1_addr_i, // DMA address
  output reg m0_valid_o, // Processor decode valid
  output reg [2:0] m0_tgt_o, // Processor target
  output reg m0_error_o, // Processor abort
  output reg m1_valid_o, // DMA decode valid
  output reg [2:0] m1_tgt_o, // DMA target
  output reg m1_error_o, // DMA abort
  output reg [7:0] ext_select_n_o, // External selects, active low
  output reg sdram_select_line_o, // SDRAM select
  output reg nand_en_o, // NAND support active on select three
  output reg card_en_o, // Card slot logic active on four or five
  output reg [25:0] ext_addr_o, // External address
  output reg [19:0] int_addr_o, // Internal memory offset
  output reg sysc_sel_o, // System controller window hit
  output reg boot_rom_o, // Captured boot source
  output reg smc_byte_sel_o, // Static controller byte select mode
  output reg [1:0] smc_dbw_o, // Static controller bus width
  output reg smc_cs_strobe_o // Static controller strobes by select
);
  // Boot pin synchroniser and capture state
  reg bs_s1_q, bs_s2_q, bs_s3_q; // Three-stage pin sampler
  reg [1:0] boot_cnt_q; // Settle count after release
  reg boot_rom_q; // Latched boot source
  reg boot_done_q; // Capture finished
  // Lane results
  wire v0, v1, e0, e1, s0, s1, sy0, sy1;
  wire [2:0] t0, t1, c0, c1;
  wire [25:0] xa0, xa1;
  wire [19:0] ia0, ia1;

  // Sample the pin; capture once sampler agrees after reset
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bs_s1_q <= 1'b0;
      bs_s2_q <= 1'b0;
      bs_s3_q <= 1'b0;
      boot_cnt_q <= 2'h0;
      boot_rom_q <= 1'b0;
      boot_done_q <= 1'b0;
    end else begin
      bs_s1_q <= boot_source_select_pin_i;
      bs_s2_q <= bs_s1_q;
      bs_s3_q <= bs_s2_q;
      if (!boot_done_q) begin
        if (boot_cnt_q != 2'h3) begin
          boot_cnt_q <= boot_cnt_q + 2'h1; // Fill the sampler
        end else if (bs_s2_q == bs_s3_q) begin
          boot_rom_q <= bs_s3_q; // [R20] [R09] [R10]
          boot_done_q <= 1'b1; // Frozen until next reset
        end
      end
    end
  end

  // Separate decoder per master
  mmdec_lane u_m0 ( // [R06] processor sees boot choice
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .boot_rom_i(boot_rom_q), .boot_en_i(1'b1),
    .sdram_on_cs1_i(cfg_sdram_on_cs1_i),
    .req_i(m0_req_i && boot_done_q), .addr_i(m0_addr_i),
    .sel_valid_o(v0), .tgt_o(t0), .cs_o(c0), .sdram_o(s0),
    .ext_addr_o(xa0), .int_addr_o(ia0), .sysc_o(sy0), .error_o(e0));
  mmdec_lane u_m1 ( // [R06] same map, no boot alternative
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .boot_rom_i(boot_rom_q), .boot_en_i(1'b0),
    .sdram_on_cs1_i(cfg_sdram_on_cs1_i),
    .req_i(m1_req_i && boot_done_q), .addr_i(m1_addr_i),
    .sel_valid_o(v1), .tgt_o(t1), .cs_o(c1), .sdram_o(s1),
    .ext_addr_o(xa1), .int_addr_o(ia1), .sysc_o(sy1), .error_o(e1));

  // Drive outputs; processor wins shared external port
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m0_valid_o <= 1'b0;
      m0_tgt_o <= `MMDEC_TGT_NONE;
      m0_error_o <= 1'b0;
      m1_valid_o <= 1'b0;
      m1_tgt_o <= `MMDEC_TGT_NONE;
      m1_error_o <= 1'b0;
      ext_select_n_o <= 8'hFF;
      sdram_select_line_o <= 1'b0;
      nand_en_o <= 1'b0;
      card_en_o <= 1'b0;
      ext_addr_o <= 26'h0000000;
      int_addr_o <= 20'h00000;
      sysc_sel_o <= 1'b0;
      boot_rom_o <= 1'b0;
      smc_byte_sel_o <= `MMDEC_SMC_BYTE_SEL; // [R11]
      smc_dbw_o <= `MMDEC_SMC_DBW16; // [R11]
      smc_cs_strobe_o <= `MMDEC_SMC_CS_STROBE; // [R11]
    end else begin
      m0_valid_o <= v0;
      m0_tgt_o <= t0;
      m0_error_o <= e0; // [R05]
      m1_valid_o <= v1;
      m1_tgt_o <= t1;
      m1_error_o <= e1; // [R05]
      boot_rom_o <= boot_rom_q;
      int_addr_o <= (t0 != `MMDEC_TGT_NONE) ? ia0 : ia1;
      sysc_sel_o <= sy0 | sy1; // [R17]
      ext_select_n_o <= 8'hFF; // No select on error [R21]
      sdram_select_line_o <= 1'b0;
      nand_en_o <= 1'b0;
      card_en_o <= 1'b0;
      if (t0 == `MMDEC_TGT_EXT) begin
        ext_addr_o <= xa0; // [R16]
        if (s0) begin
          sdram_select_line_o <= 1'b1; // [R13] [R19]
        end else begin
          ext_select_n_o <= ~(8'h01 << c0); // [R12]
        end
        nand_en_o <= (c0 == 3'h3) && cfg_nand_on_cs3_i; // [R14] [R19]
        card_en_o <= (c0 == 3'h4 || c0 == 3'h5) &&
                     cfg_card_on_cs45_i; // [R15] [R19]
      end else if (t1 == `MMDEC_TGT_EXT) begin
        ext_addr_o <= xa1;
        if (s1) begin
          sdram_select_line_o <= 1'b1; // [R13]
        end else begin
          ext_select_n_o <= ~(8'h01 << c1); // [R12]
        end
        nand_en_o <= (c1 == 3'h3) && cfg_nand_on_cs3_i; // [R14]
        card_en_o <= (c1 == 3'h4 || c1 == 3'h5) &&
                     cfg_card_on_cs45_i; // [R15]
      end
    end
  end
  // Bank field is top nibble throughout the lanes [R01]
endmodule // mmdec_top
`default_nettype wire

// >>> mmdec_monitor.sv
`default_nettype none
// Watches the decoder ports and checks bank routing
module mmdec_monitor (
  input wire logic ref_clk_i, // Clock
  input wire logic nrst_i, // Reset, active low
  input wire logic cfg_sdram_on_cs1_i, // SDRAM on select one
  input wire logic m0_req_i, // Processor request
  input wire logic [31:0] m0_addr_i, // Processor address
  input wire logic m1_req_i, // DMA request
  input wire logic [31:0] m1_addr_i, // DMA address
  input wire logic m0_error_o, // Processor abort
  input wire logic [2:0] m0_tgt_o, // Processor target
  input wire logic m1_valid_o, // DMA valid
  input wire logic [2:0] m1_tgt_o, // DMA target
  input wire logic [7:0] ext_select_n_o, // Selects, active low
  input wire logic sdram_select_line_o, // SDRAM select
  input wire logic sysc_sel_o, // System window hit
  input wire logic boot_rom_o, // Captured boot source
  input wire logic smc_byte_sel_o, // Byte select mode
  input wire logic [1:0] smc_dbw_o, // Bus width
  input wire logic smc_cs_strobe_o // Strobe by select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [2:0] cnt_q; // Edges since release, saturating
  wire logic rdy = cnt_q == 3'h7; // Boot level captured
  wire logic [3:0] b0 = m0_addr_i[31:28]; // Processor bank
  wire logic [2:0] cs0 = b0[2:0] - 3'h1; // Expected select index
  wire logic sys0 = m0_addr_i >= 32'hFFFF_C000; // System window
  // Count edges after reset so early requests are skipped
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) cnt_q <= 3'h0;
    else if (!rdy) cnt_q <= cnt_q + 3'h1;
  end
  a_unused_abort:
    assert property (rdy && m0_req_i && b0 > 4'h8 && b0 < 4'hF
      |-> ##2 m0_error_o && m0_tgt_o == 3'h0) else $error("no abort");
  a_ext_select:
    assert property (rdy && m0_req_i && b0 > 4'h0 && b0 < 4'h9 &&
      !cfg_sdram_on_cs1_i |-> ##2 ext_select_n_o == ~(8'h01 << $past(cs0, 2)))
      else $error("bad select");
  a_periph_sysc:
    assert property (rdy && m0_req_i && !m1_req_i && b0 == 4'hF
      |-> ##2 m0_tgt_o == 3'h5 && sysc_sel_o == $past(sys0, 2))
      else $error("bad peripheral");
  a_boot_target:
    assert property (rdy && m0_req_i && m0_addr_i[31:20] == 12'h000 |-> ##2
      (boot_rom_o ? m0_tgt_o == 3'h1 : ext_select_n_o == 8'hFE))
      else $error("bad boot");
  a_dma_rom:
    assert property (rdy && m1_req_i && m1_addr_i[31:20] == 12'h000
      |-> ##2 m1_valid_o && m1_tgt_o == 3'h1) else $error("bad dma");
  a_sdram_bank:
    assert property (rdy && m0_req_i && b0 == 4'h2 && cfg_sdram_on_cs1_i
      |-> ##2 sdram_select_line_o && ext_select_n_o == 8'hFF)
      else $error("bad sdram");
  a_smc_default:
    assert property (smc_byte_sel_o && smc_dbw_o == 2'h1 && smc_cs_strobe_o)
      else $error("bad smc");
  a_boot_stable:
    assert property (rdy |-> $stable(boot_rom_o)) else $error("boot moved");
endmodule // mmdec_monitor
bind mmdec_top mmdec_monitor mmdec_monitor_inst (.*);
`default_nettype wire

// >>> mmdec_master.sv
`default_nettype none
// Bus master issuing one-cycle level requests
module mmdec_master (
  input wire logic clk_i, // Clock
  output logic req_o, // Request
  output logic [31:0] addr_o // Address
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_o = 1'b0;
    addr_o = 32'h0000_0000;
  end
  // Idle address is scrambled so a stale value never helps
  task automatic issue(input logic [31:0] a);
    @(posedge clk_i);
    req_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    req_o <= 1'b0;
    addr_o <= ~a;
  endtask
endmodule // mmdec_master
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i, nrst_i, boot_source_select_pin_i; // Clock, reset, pin
  logic cfg_sdram_on_cs1_i, cfg_nand_on_cs3_i, cfg_card_on_cs45_i; // Config
  logic m0_req_i, m1_req_i, m0_valid_o, m0_error_o, m1_valid_o, m1_error_o;
  logic sdram_select_line_o, nand_en_o, card_en_o, sysc_sel_o, boot_rom_o;
  logic smc_byte_sel_o, smc_cs_strobe_o; // Controller defaults
  logic [1:0] smc_dbw_o; // Bus width
  logic [2:0] m0_tgt_o, m1_tgt_o; // Targets
  logic [7:0] ext_select_n_o; // Selects
  logic [25:0] ext_addr_o; // External address
  logic [19:0] int_addr_o; // Internal offset
  logic [31:0] m0_addr_i, m1_addr_i; // Addresses
  int n_fail, n_tests; // Counters
  mmdec_top mmdec_top_inst (.*);
  mmdec_master m0_inst (.clk_i(ref_clk_i), .req_o(m0_req_i), .addr_o(m0_addr_i));
  mmdec_master m1_inst (.clk_i(ref_clk_i), .req_o(m1_req_i), .addr_o(m1_addr_i));
  // Clock, 50 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Reset with a given boot level, then wait out the capture
  task automatic rst(input logic pin);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    boot_source_select_pin_i <= pin;
    repeat (4) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
  endtask
  // Processor access; answer stands two edges after taking
  task automatic op(input logic [31:0] a, input logic [2:0] t, input logic e);
    m0_inst.issue(a);
    @(posedge ref_clk_i);
    #1;
    chk(m0_tgt_o, t);
    chk(m0_error_o, e);
    chk(m0_valid_o, !e);
  endtask
  task automatic t_banks();
    for (int b = 0; b < 16; b++) begin
      op({b[3:0], 28'h000_0010}, b == 0 ? 1 : b < 9 ? 4 : b == 15 ? 5 : 0,
        b > 8 && b < 15);
      if (b > 0 && b < 9) chk(ext_select_n_o, 8'(~(8'h01 << (b - 1))));
      else chk(ext_select_n_o, 8'hFF);
    end
    chk(boot_rom_o, 1'b1);
    $display("t_banks done");
  endtask
  task automatic t_internal();
    op(32'h0010_0000, 3'h1, 1'b0);
    op(32'h0020_0123, 3'h2, 1'b0);
    chk(int_addr_o, 20'h00123);
    op(32'h0030_0000, 3'h3, 1'b0);
    op(32'h0040_0000, 3'h0, 1'b1);
    $display("t_internal done");
  endtask
  task automatic t_options();
    @(posedge ref_clk_i);
    cfg_sdram_on_cs1_i <= 1'b1;
    cfg_nand_on_cs3_i <= 1'b1;
    cfg_card_on_cs45_i <= 1'b1;
    op(32'h2000_0000, 3'h4, 1'b0);
    chk(sdram_select_line_o, 1'b1);
    op(32'h4000_0000, 3'h4, 1'b0);
    chk(nand_en_o, 1'b1);
    op(32'h6000_0000, 3'h4, 1'b0);
    chk(card_en_o, 1'b1);
    chk(ext_select_n_o, 8'hDF);
    @(posedge ref_clk_i);
    cfg_sdram_on_cs1_i <= 1'b0;
    cfg_nand_on_cs3_i <= 1'b0;
    cfg_card_on_cs45_i <= 1'b0;
    op(32'h4000_0000, 3'h4, 1'b0);
    chk(nand_en_o, 1'b0);
    op(32'h5000_0000, 3'h4, 1'b0);
    chk(card_en_o, 1'b0);
    chk(ext_select_n_o, 8'hEF);
    op(32'h2000_0000, 3'h4, 1'b0);
    chk({sdram_select_line_o, ext_select_n_o}, 9'h0FD);
    $display("t_options done");
  endtask
  task automatic t_periph();
    op(32'hFFFF_C004, 3'h5, 1'b0);
    chk(sysc_sel_o, 1'b1);
    op(32'hFFFF_BFFC, 3'h5, 1'b0);
    chk(sysc_sel_o, 1'b0);
    op(32'h13FF_FFFF, 3'h4, 1'b0);
    chk(ext_addr_o, 26'h3FF_FFFF);
    $display("t_periph done");
  endtask
  // Second reset with the pin low: processor boots external
  task automatic t_boot_low();
    rst(1'b0);
    chk(boot_rom_o, 1'b0);
    chk({smc_byte_sel_o, smc_dbw_o, smc_cs_strobe_o}, 4'hB);
    fork
      m1_inst.issue(32'h0000_0040);
      op(32'h0000_0040, 3'h4, 1'b0);
    join
    chk(ext_select_n_o, 8'hFE);
    chk({m1_valid_o, m1_tgt_o}, 4'h9);
    fork
      m1_inst.issue(32'h8000_0000);
      op(32'h9000_0000, 3'h0, 1'b1);
    join
    chk(ext_select_n_o, 8'h7F);
    chk({m1_error_o, m1_valid_o, m1_tgt_o}, 5'h0C);
    fork
      m1_inst.issue(32'hA000_0000);
      op(32'h1000_0000, 3'h4, 1'b0);
    join
    chk(ext_select_n_o, 8'hFE);
    chk({m1_error_o, m1_valid_o, m1_tgt_o}, 5'h10);
    $display("t_boot_low done");
  endtask
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    n_fail++;
    conclude();
  end
  // Main sequence
  initial begin
    {nrst_i, boot_source_select_pin_i, n_fail, n_tests} = '0;
    {cfg_sdram_on_cs1_i, cfg_nand_on_cs3_i, cfg_card_on_cs45_i} = 3'h0;
    rst(1'b1);
    t_banks();
    t_internal();
    t_options();
    t_periph();
    t_boot_low();
    conclude();
  end
endmodule // testbench
`default_nettype wire
